// *** hw/adc_conversion_sequencer.sv ***
/*
 * Control sequencer of a 10-bit successive-approximation converter:
 * two control registers, two result registers, single and repeat modes,
 * done and busy flags, a done pulse and standby handling.
 * Assumes the analog core holds conv_code steady near the end of a
 * conversion, and that standby is driven by the power controller on clk.
 */
// Overview of operation
// - Mode single plus start write begins converting the selected channel.
// - At conversion end store result, set done flag, pulse done interrupt together.
// - Start bit clears itself once conversion begins; reads back as zero.
// - Mode repeat plus start write begins repeated conversions of selected channel.
// - In repeat mode each completed conversion starts the next automatically.
// - Writing mode disable aborts at once without storing the partial result.
// - Reading the high result clears the done flag.
// - New start clears done flag but keeps old result until completion.
// - Standby entry aborts, initialises both control registers, clears the result.
// - After standby the sequencer stays idle until software starts again.
// - In standby the reference connection is opened.
// - Each conversion yields an unsigned 10-bit code.
// - Channel codes with the top bit set are reserved.
// - Busy rises at start, falls at a single-mode finish, and clears on standby entry.
// - High result holds bits 9..2; low holds bits 1..0, done, busy.
`timescale 1ns/100ps
module adc_conversion_sequencer #(
    parameter int CODE_W = adc_seq_pkg::CODE_W
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire adc_seq_pkg::reg_req_t  req,
    output logic [7:0]                  rdata,
    input  wire logic                   standby,
    input  wire logic [CODE_W-1:0]      conv_code,
    output adc_seq_pkg::core_ctrl_t     core_ctrl,
    output logic                        conv_done_irq
);

    adc_seq_pkg::seq_state_t state_q;
    adc_seq_pkg::seq_state_t state_d;
    adc_seq_pkg::core_ctrl_t core_q;

    logic [7:0]        ctrl1_q;
    logic [7:0]        ctrl2_q;
    logic [CODE_W-1:0] result_q;
    logic [CODE_W-1:0] code_meta_q;
    logic [CODE_W-1:0] code_sync_q;
    logic              done_q;
    logic              irq_q;
    logic [7:0]        rdata_q;
    logic [10:0]       conv_cycles_q;
    logic [10:0]       span_q;

    logic       wr_c1;
    logic       wr_c2;
    logic       rd_high;
    logic [1:0] wr_mode;
    logic [1:0] mode_q;
    logic       wr_mode_ok;
    logic       go;
    logic       abort;
    logic       complete;
    logic       expired;
    logic       repeat_now;
    logic       busy;
    logic       timer_load;
    logic [10:0] sel_cycles;

    // Standby blocks every write: registers sit at their initial values
    assign wr_c1   = req.we && (req.addr == adc_seq_pkg::CTRL_ONE_ADDR) && !standby;
    assign wr_c2   = req.we && (req.addr == adc_seq_pkg::CTRL_TWO_ADDR) && !standby;
    assign rd_high = req.re && (req.addr == adc_seq_pkg::RES_HIGH_ADDR);
    assign wr_mode = req.wdata[adc_seq_pkg::MODE_LSB +: adc_seq_pkg::MODE_W];
    assign mode_q  = ctrl1_q[adc_seq_pkg::MODE_LSB +: adc_seq_pkg::MODE_W];
    assign wr_mode_ok = (wr_mode == adc_seq_pkg::MODE_SINGLE) ||
                        (wr_mode == adc_seq_pkg::MODE_REPEAT);
    assign busy       = (state_q == adc_seq_pkg::ST_CONV);
    assign repeat_now = (mode_q == adc_seq_pkg::MODE_REPEAT);
    assign sel_cycles = adc_seq_pkg::conv_cycles(
                            ctrl2_q[adc_seq_pkg::TIME_LSB +: adc_seq_pkg::TIME_W]);

    // A start written with a reserved channel is dropped
    assign go = wr_c1 && req.wdata[adc_seq_pkg::START_BIT] && wr_mode_ok &&
                !req.wdata[adc_seq_pkg::CH_RSV];

    // Mode 10 is not a run mode, so it stops the converter like 00
    assign abort = standby || (wr_c1 && !wr_mode_ok);

    // A restart discards the running conversion rather than storing it
    assign complete   = expired && busy && !abort && !go;
    assign timer_load = go || (complete && repeat_now);

    conv_timer #(
        .WIDTH (adc_seq_pkg::TIMER_W)
    ) u_timer (
        .clk      (clk),
        .reset    (reset),
        .load     (timer_load),
        .load_val (sel_cycles - 11'h001),
        .run      (busy),
        .expired  (expired)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            adc_seq_pkg::ST_IDLE: begin
                if (go) begin
                    state_d = adc_seq_pkg::ST_CONV;
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (abort) begin
                    state_d = adc_seq_pkg::ST_IDLE;
                end else if (complete && !repeat_now) begin
                    state_d = adc_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = adc_seq_pkg::ST_IDLE;
            end
        endcase
        if (standby) begin
            state_d = adc_seq_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= adc_seq_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Start bit is never stored, so it always reads back as zero
    always_ff @(posedge clk) begin
        if (reset || standby) begin
            ctrl1_q <= adc_seq_pkg::CTRL_ONE_RST;
        end else if (wr_c1) begin
            ctrl1_q <= req.wdata & ~(8'h01 << adc_seq_pkg::START_BIT);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || standby) begin
            ctrl2_q <= adc_seq_pkg::CTRL_TWO_RST;
        end else if (wr_c2) begin
            ctrl2_q <= req.wdata & adc_seq_pkg::CTRL_TWO_MASK;
        end
    end

    // The core output is asynchronous to us; two stages before use
    always_ff @(posedge clk) begin
        if (reset) begin
            code_meta_q <= '0;
            code_sync_q <= '0;
        end else begin
            code_meta_q <= conv_code;
            code_sync_q <= code_meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || standby) begin
            result_q <= adc_seq_pkg::RESULT_RST;
        end else if (complete) begin
            result_q <= code_sync_q;
        end
    end

    // Completion beats a same-cycle read, so no finished result goes unseen
    always_ff @(posedge clk) begin
        if (reset || standby) begin
            done_q <= 1'b0;
        end else if (complete) begin
            done_q <= 1'b1;
        end else if (go || rd_high) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= complete;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            conv_cycles_q <= adc_seq_pkg::CONV_CYC_1248;
        end else if (timer_load) begin
            conv_cycles_q <= sel_cycles;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || standby) begin
            core_q <= '0;
        end else begin
            core_q.channel           <= ctrl1_q[adc_seq_pkg::CH_LSB +: adc_seq_pkg::CH_W];
            core_q.input_disable     <= ctrl1_q[adc_seq_pkg::INDIS_BIT];
            core_q.sample_active     <= (state_d == adc_seq_pkg::ST_CONV);
            core_q.reference_connect <= ctrl2_q[adc_seq_pkg::REF_ON_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (req.re) begin
            case (req.addr)
                adc_seq_pkg::CTRL_ONE_ADDR: rdata_q <= ctrl1_q;
                adc_seq_pkg::CTRL_TWO_ADDR: rdata_q <= ctrl2_q;
                adc_seq_pkg::RES_HIGH_ADDR: rdata_q <= result_q[CODE_W-1 -: 8];
                adc_seq_pkg::RES_LOW_ADDR: begin
                    rdata_q <= {result_q[1:0], done_q, busy, 4'h0};
                end
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata         = rdata_q;
    assign core_ctrl     = core_q;
    assign conv_done_irq = irq_q;

    // Busy cycles of the running conversion, read only by a check below
    always_ff @(posedge clk) begin
        if (reset || go || complete || !busy) begin
            span_q <= 11'h000;
        end else begin
            span_q <= span_q + 11'h001;
        end
    end

    chk_single_start: assert property (
        @(posedge clk) disable iff (reset)
        (go && (wr_mode == adc_seq_pkg::MODE_SINGLE)) |=> busy ##1
        (core_q.channel == $past(req.wdata[3:0], 2)))
    else $error("single start did not begin conversion of the channel");

    chk_done_with_result: assert property (
        @(posedge clk) disable iff (reset)
        irq_q |-> (done_q && (result_q == $past(code_sync_q))))
    else $error("done pulse without done flag and stored result");

    chk_start_reads_zero: assert property (
        @(posedge clk) disable iff (reset)
        (req.re && (req.addr == adc_seq_pkg::CTRL_ONE_ADDR)) |=>
        (rdata_q[adc_seq_pkg::START_BIT] == 1'b0))
    else $error("start bit read back as one");

    chk_repeat_continue: assert property (
        @(posedge clk) disable iff (reset)
        irq_q |-> (busy == ($past(mode_q) == adc_seq_pkg::MODE_REPEAT)))
    else $error("repeat mode did not restart, or single mode did");

    chk_disable_abort: assert property (
        @(posedge clk) disable iff (reset)
        (wr_c1 && (wr_mode == adc_seq_pkg::MODE_OFF)) |=>
        (!busy && !irq_q && (result_q == $past(result_q))))
    else $error("disable did not abort cleanly");

    chk_read_clears_done: assert property (
        @(posedge clk) disable iff (reset)
        (rd_high && !complete) |=> !done_q)
    else $error("reading the result left done set");

    chk_restart_keeps: assert property (
        @(posedge clk) disable iff (reset)
        go |=> (!done_q && (result_q == $past(result_q))))
    else $error("restart changed result or kept done");

    chk_standby_init: assert property (
        @(posedge clk) disable iff (reset)
        standby |=> ((ctrl1_q == adc_seq_pkg::CTRL_ONE_RST) &&
                     (ctrl2_q == adc_seq_pkg::CTRL_TWO_RST) &&
                     (result_q == adc_seq_pkg::RESULT_RST) && !busy && !done_q))
    else $error("standby did not initialise the converter");

    chk_idle_after_standby: assert property (
        @(posedge clk) disable iff (reset)
        ($past(standby) && !standby) |-> (!busy && !core_q.sample_active))
    else $error("converter active right after standby");

    chk_reference_open: assert property (
        @(posedge clk) disable iff (reset)
        standby |=> !core_q.reference_connect)
    else $error("reference still connected in standby");

    chk_reserved_channel: assert property (
        @(posedge clk) disable iff (reset)
        (wr_c1 && !busy && req.wdata[adc_seq_pkg::CH_RSV]) |=> !busy)
    else $error("conversion began on a reserved channel");

    chk_conv_length: assert property (
        @(posedge clk) disable iff (reset)
        complete |-> (span_q == (conv_cycles_q - 11'h001)))
    else $error("conversion length differs from selected count");

    chk_busy_on_start: assert property (
        @(posedge clk) disable iff (reset)
        go |=> (busy && core_q.sample_active))
    else $error("start did not raise busy");

    chk_busy_on_finish: assert property (
        @(posedge clk) disable iff (reset)
        (complete && !repeat_now) |=>
        (!busy && !core_q.sample_active && irq_q && done_q))
    else $error("single conversion end left busy set");

    chk_irq_single_pulse: assert property (
        @(posedge clk) disable iff (reset)
        irq_q |-> ($past(busy) ##1 !irq_q))
    else $error("done pulse too long or without a conversion");

    chk_result_holds: assert property (
        @(posedge clk) disable iff (reset)
        (!complete && !standby) |=> (result_q == $past(result_q)))
    else $error("result changed without a finished conversion");

    chk_done_holds: assert property (
        @(posedge clk) disable iff (reset)
        (done_q && !rd_high && !go && !standby) |=> done_q)
    else $error("done flag dropped without a read or a start");

    // Deliberately not disabled by reset: it checks what reset leaves behind
    chk_reset_idle: assert property (
        @(posedge clk)
        reset |=> (!busy && !done_q && !irq_q &&
                   (ctrl1_q == adc_seq_pkg::CTRL_ONE_RST)))
    else $error("reset did not leave the converter idle");

    chk_sample_is_busy: assert property (
        @(posedge clk) disable iff (reset)
        core_q.sample_active == busy)
    else $error("core sample control differs from busy flag");

endmodule

// *** hw/adc_seq_pkg.sv ***
/*
 * Shared constants and types of the conversion sequencer: register offsets,
 * field positions, reset values, mode codes, conversion lengths, states and
 * the structs that carry the register port and the analog core controls.
 * Assumes the system clock is the converter clock, so lengths are in cycles.
 */
package adc_seq_pkg;

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int CODE_W  = 10;
    localparam int TIMER_W = 11;

    // Register offsets
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h1e;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h1f;
    localparam logic [7:0] RES_HIGH_ADDR = 8'h20;
    localparam logic [7:0] RES_LOW_ADDR  = 8'h21;

    // Field positions of conv_control_one
    localparam int START_BIT = 7;
    localparam int MODE_LSB  = 5;
    localparam int MODE_W    = 2;
    localparam int INDIS_BIT = 4;
    localparam int CH_LSB    = 0;
    localparam int CH_W      = 4;
    localparam int CH_RSV    = 3;

    // Field positions of conv_control_two
    localparam int REF_ON_BIT = 5;
    localparam int TIME_LSB   = 1;
    localparam int TIME_W     = 3;
    localparam logic [7:0] CTRL_TWO_MASK = 8'h3f;

    // Field positions of result_low_status_reg
    localparam int DONE_BIT = 5;
    localparam int BUSY_BIT = 4;
    localparam int LOW_LSB  = 6;

    // Reset values
    localparam logic [7:0]  CTRL_ONE_RST = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RST = 8'h00;
    localparam logic [9:0]  RESULT_RST   = 10'h000;

    // Mode codes
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;

    // Conversion lengths in converter clock periods
    localparam logic [10:0] CONV_CYC_39   = 11'h027;
    localparam logic [10:0] CONV_CYC_78   = 11'h04e;
    localparam logic [10:0] CONV_CYC_156  = 11'h09c;
    localparam logic [10:0] CONV_CYC_312  = 11'h138;
    localparam logic [10:0] CONV_CYC_624  = 11'h270;
    localparam logic [10:0] CONV_CYC_1248 = 11'h4e0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] channel;
        logic       input_disable;
        logic       sample_active;
        logic       reference_connect;
    } core_ctrl_t;

    // Reserved time codes fall back to the longest, safest length
    function automatic logic [10:0] conv_cycles(input logic [2:0] sel);
        case (sel)
            3'h0:    return CONV_CYC_39;
            3'h2:    return CONV_CYC_78;
            3'h3:    return CONV_CYC_156;
            3'h4:    return CONV_CYC_312;
            3'h5:    return CONV_CYC_624;
            default: return CONV_CYC_1248;
        endcase
    endfunction

endpackage

// *** hw/conv_timer.sv ***
/*
 * Down counter that times one conversion: loaded with length minus one,
 * it flags expiry in the last cycle of the conversion.
 * Assumes load and run come from logic on the same clock.
 */
`timescale 1ns/100ps
module conv_timer #(
    parameter int WIDTH = 11
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             run,
    output logic                  expired
);

    logic [WIDTH-1:0] cnt_q;

    assign expired = run && (cnt_q == '0);

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (run && (cnt_q != '0)) begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench of the conversion sequencer: register port, single and
 * repeat conversions, abort, standby and reset.
 * Assumes the sequencer package is compiled first and that the design
 * carries its own assertions.
 */
`timescale 1ns/100ps
module tb;
    logic                     clk;
    logic                     reset;
    logic                     standby;
    adc_seq_pkg::reg_req_t    req;
    logic [7:0]               rdata;
    logic [9:0]               conv_code;
    adc_seq_pkg::core_ctrl_t  core_ctrl;
    logic                     conv_done_irq;
    int                       failures;
    int                       n_tests;
    int                       n;
    logic [9:0]               a;
    logic [9:0]               b;
    logic [3:0]               ch;
    logic                     ind;

    adc_conversion_sequencer u_adc_conversion_sequencer (
        .clk           (clk),
        .reset         (reset),
        .req           (req),
        .rdata         (rdata),
        .standby       (standby),
        .conv_code     (conv_code),
        .core_ctrl     (core_ctrl),
        .conv_done_irq (conv_done_irq)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        @(posedge clk);
        req.addr  <= ad;
        req.wdata <= wd;
        req.we    <= 1'b1;
        @(posedge clk);
        req.we    <= 1'b0;
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        req.addr <= ad;
        req.re   <= 1'b1;
        @(posedge clk);
        req.re   <= 1'b0;
        #1;
        chk_reg(rdata, exp);
    endtask

    // Counts edges until the done pulse; 0 means it never came
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        for (int i = 1; i <= lim; i++) begin
            @(posedge clk);
            #1;
            if (conv_done_irq === 1'b1) begin
                cnt = i;
                break;
            end
        end
    endtask

    function automatic int exp_cyc(input logic [2:0] tc);
        case (tc)
            3'h0:    return 39;
            3'h2:    return 78;
            3'h3:    return 156;
            3'h4:    return 312;
            3'h5:    return 624;
            default: return 1248;
        endcase
    endfunction

    function automatic logic [7:0] exp_low(input logic [9:0] c, input logic dn,
                                           input logic bz);
        return {c[1:0], dn, bz, 4'h0};
    endfunction

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial begin
        reset     = 1'b1;
        standby   = 1'b0;
        req       = '0;
        conv_code = '0;
        failures  = 0;
        n_tests   = 0;
        void'($urandom(32'h9855));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_chk(8'h1e, 8'h00);
        rd_chk(8'h1f, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h55, 8'h00);
        for (int tc = 0; tc < 8; tc++) begin
            ch = 4'($urandom_range(7, 1));
            ind = 1'($urandom);
            a = 10'($urandom);
            conv_code <= a;
            wr(8'h1f, {4'h3, 3'(tc), 1'b0});
            rd_chk(8'h1f, {4'h3, 3'(tc), 1'b0});
            wr(8'h1e, {3'h5, ind, ch});
            #1;
            chk_reg({7'h0, core_ctrl.sample_active}, 8'h01);
            wait_irq(1300, n);
            chk_cnt(n, exp_cyc(3'(tc)));
            rd_chk(8'h21, exp_low(a, 1'b1, 1'b0));
            rd_chk(8'h20, a[9:2]);
            rd_chk(8'h21, exp_low(a, 1'b0, 1'b0));
            rd_chk(8'h1e, {3'h1, ind, ch});
            chk_reg({4'h0, core_ctrl.channel}, {4'h0, ch});
            chk_reg({7'h0, core_ctrl.input_disable}, {7'h0, ind});
            chk_reg({7'h0, core_ctrl.reference_connect}, 8'h01);
        end
        // New start before the result is read keeps the old result
        a = 10'($urandom);
        b = ~a;
        conv_code <= a;
        wr(8'h1f, 8'h30);
        wr(8'h1e, 8'ha3);
        wait_irq(100, n);
        chk_cnt(n, 39);
        conv_code <= b;
        wr(8'h1e, 8'ha3);
        rd_chk(8'h21, exp_low(a, 1'b0, 1'b1));
        rd_chk(8'h20, a[9:2]);
        wait_irq(100, n);
        chk_cnt(n, 35);
        rd_chk(8'h21, exp_low(b, 1'b1, 1'b0));
        // Repeat mode, then abort by mode 00
        conv_code <= a;
        wr(8'h1f, 8'h36);
        wr(8'h1e, 8'he3);
        wait_irq(200, n);
        chk_cnt(n, 156);
        conv_code <= b;
        wait_irq(200, n);
        chk_cnt(n, 156);
        rd_chk(8'h21, exp_low(b, 1'b1, 1'b1));
        rd_chk(8'h20, b[9:2]);
        conv_code <= a;
        wr(8'h1e, 8'h03);
        rd_chk(8'h21, exp_low(b, 1'b0, 1'b0));
        wait_irq(400, n);
        chk_cnt(n, 0);
        rd_chk(8'h20, b[9:2]);
        // Standby in mid-conversion
        wr(8'h1f, 8'h30);
        wr(8'h1e, 8'ha5);
        repeat (5) @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        #1;
        chk_reg({1'b0, core_ctrl}, 8'h00);
        wr(8'h1f, 8'h3e);
        rd_chk(8'h1f, 8'h00);
        @(posedge clk);
        standby <= 1'b0;
        rd_chk(8'h1e, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h20, 8'h00);
        wait_irq(100, n);
        chk_cnt(n, 0);
        // Reserved channel code, write to a result register
        wr(8'h1e, 8'ha8);
        #1;
        chk_reg({7'h0, core_ctrl.sample_active}, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h1e, 8'h28);
        wr(8'h20, 8'hff);
        rd_chk(8'h20, 8'h00);
        // Mode 10 stops a running conversion like mode 00
        wr(8'h1e, 8'ha2);
        repeat (3) @(posedge clk);
        wr(8'h1e, 8'h42);
        rd_chk(8'h21, 8'h00);
        wait_irq(100, n);
        chk_cnt(n, 0);
        // Reset in mid-conversion
        wr(8'h1e, 8'ha1);
        repeat (3) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_chk(8'h1e, 8'h00);
        rd_chk(8'h21, 8'h00);
        wait_irq(100, n);
        chk_cnt(n, 0);
        end_sim();
    end
endmodule
